// file: rtl/sadc_ctrl.sv
`timescale 1ns/1ps
module sadc_ctrl
  import sadc_pkg::*;
#(
  parameter int DIV_CNT_W = 5
) (
  // System
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Interrupt and shared flags
  input  wire logic        conv_irq_en,
  input  wire logic [2:0]  aux_flag_set,
  output logic             conv_irq,
  // Power mode
  input  wire logic        low_power_mode,
  // Analog front end
  input  wire logic        cmp_in,
  output logic      [4:0]  ana_chan_sel,
  output logic             ana_chan_valid,
  output logic             ana_ref_bandgap,
  output logic             ana_bg_level_hi,
  output logic             ana_bg_level_lo,
  output logic             ana_bg_enable,
  output logic             ana_sample,
  output logic      [11:0] ana_dac_code,
  output logic             conv_clk,
  output logic             busy
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [7:0]  opt_r;
  logic [7:0]  opt_nxt;
  logic [7:0]  flg_r;
  logic [7:0]  flg_nxt;
  logic [7:0]  chs_r;
  logic [7:0]  chs_nxt;
  logic [7:0]  ctl_r;
  logic [7:0]  ctl_nxt;
  logic [11:0] res_r;
  logic [11:0] res_nxt;
  logic [7:0]  rdata_r;
  logic [7:0]  rdata_nxt;

  sadc_state_t state_r;
  sadc_state_t state_nxt;
  logic [4:0]  cyc_r;
  logic [4:0]  cyc_nxt;
  logic [3:0]  idx_r;
  logic [3:0]  idx_nxt;
  logic        phase_r;
  logic        phase_nxt;
  logic [11:0] sar_r;
  logic [11:0] sar_nxt;
  logic [11:0] sar_dec;
  logic        conv_finish;

  logic        wr_opt;
  logic        wr_flg;
  logic        wr_chs;
  logic        wr_ctl;
  logic        start_wr;
  logic        conv_tick;
  logic        conv_clk_i;
  logic [4:0]  chan_code;
  logic        use_bandgap;

  logic [4:0]  chan_r;
  logic        chan_ok_r;
  logic        ref_bg_r;
  logic        lvl_hi_r;
  logic        lvl_lo_r;
  logic        bg_en_r;
  logic        sample_r;
  logic        busy_r;
  logic        irq_r;
  logic        chan_ok_nxt;
  logic        bg_en_nxt;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  // Result registers have no write decode at all
  assign wr_opt   = reg_wr && (reg_addr == ADDR_MISC_OPTION);
  assign wr_flg   = reg_wr && (reg_addr == ADDR_AUX_INT_FLAGS);
  assign wr_chs   = reg_wr && (reg_addr == ADDR_INPUT_CHAN_SEL);
  assign wr_ctl   = reg_wr && (reg_addr == ADDR_AUX_CTRL_ONE);
  assign start_wr = wr_ctl && reg_wdata[CTL_START_BIT];

  // ---------------------------------------------------------------
  // Converter clock divider
  // ---------------------------------------------------------------
  sadc_clkdiv #(
    .CNT_W     (DIV_CNT_W)
  ) u_clkdiv (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .div_sel   (opt_r[OPT_DIV_SEL_LSB +: 2]),
    .restart   (start_wr),
    .conv_tick (conv_tick),
    .conv_clk  (conv_clk_i)
  );

  // ---------------------------------------------------------------
  // Successive approximation sequencer
  // ---------------------------------------------------------------
  // Trial bit replaced by the comparator decision of this cycle
  always_comb begin
    sar_dec        = sar_r;
    sar_dec[idx_r] = cmp_in;
  end

  // Next state of the sequencer
  always_comb begin
    state_nxt   = state_r;
    cyc_nxt     = cyc_r;
    idx_nxt     = idx_r;
    phase_nxt   = phase_r;
    sar_nxt     = sar_r;
    conv_finish = 1'b0;
    if (wr_ctl) begin
      if (reg_wdata[CTL_START_BIT]) begin
        // A start while busy restarts from sampling
        state_nxt = SADC_SAMPLE;
        cyc_nxt   = '0;
        idx_nxt   = RESULT_MSB;
        phase_nxt = 1'b0;
        sar_nxt   = '0;
      end else begin
        state_nxt = SADC_IDLE;
      end
    end else begin
      unique case (state_r)
        SADC_IDLE: begin
          cyc_nxt = '0;
        end
        SADC_SAMPLE: begin
          if (conv_tick) begin
            if (cyc_r == SAMPLE_LAST) begin
              state_nxt = SADC_CONVERT;
              cyc_nxt   = '0;
            end else begin
              cyc_nxt = cyc_r + 1'b1;
            end
          end
        end
        SADC_CONVERT: begin
          if (conv_tick) begin
            if (!phase_r) begin
              // First clock of a bit puts the trial on the DAC
              sar_nxt[idx_r] = 1'b1;
              phase_nxt      = 1'b1;
            end else begin
              // Second clock keeps or drops it
              sar_nxt   = sar_dec;
              phase_nxt = 1'b0;
              if (idx_r == '0) begin
                state_nxt   = SADC_IDLE;
                conv_finish = 1'b1;
              end else begin
                idx_nxt = idx_r - 1'b1;
              end
            end
          end
        end
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_r <= SADC_IDLE;
      cyc_r   <= '0;
      idx_r   <= '0;
      phase_r <= 1'b0;
      sar_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cyc_r   <= cyc_nxt;
      idx_r   <= idx_nxt;
      phase_r <= phase_nxt;
      sar_r   <= sar_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------
  // Writes first, hardware events last so a set beats a clear
  always_comb begin
    opt_nxt = opt_r;
    flg_nxt = flg_r;
    chs_nxt = chs_r;
    ctl_nxt = ctl_r;
    res_nxt = res_r;
    if (wr_opt) begin
      opt_nxt = reg_wdata & MISC_OPTION_WMASK;
    end
    if (wr_chs) begin
      chs_nxt = reg_wdata;
    end
    if (wr_ctl) begin
      ctl_nxt = reg_wdata & AUX_CTRL_ONE_WMASK;
    end
    if (wr_flg) begin
      // Flags clear on a written zero, a written one leaves them
      flg_nxt[FLG_DONE_BIT] = flg_r[FLG_DONE_BIT] & reg_wdata[FLG_DONE_BIT];
      flg_nxt[FLG_OTHER_W-1:0] = flg_r[FLG_OTHER_W-1:0] & reg_wdata[FLG_OTHER_W-1:0];
    end
    if (start_wr) begin
      flg_nxt[FLG_DONE_BIT] = 1'b0;
    end
    flg_nxt[FLG_OTHER_W-1:0] = flg_nxt[FLG_OTHER_W-1:0] | aux_flag_set;
    if (conv_finish) begin
      // Finish cannot coincide with a control write, which wins above
      ctl_nxt[CTL_START_BIT] = 1'b0;
      flg_nxt[FLG_DONE_BIT]  = 1'b1;
      res_nxt                = sar_dec;
    end
  end

  // Register storage
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      opt_r <= MISC_OPTION_RST;
      flg_r <= AUX_INT_FLAGS_RST;
      chs_r <= INPUT_CHAN_SEL_RST;
      ctl_r <= AUX_CTRL_ONE_RST;
      res_r <= {RESULT_RST, RESULT_RST[7:4]};
    end else begin
      opt_r <= opt_nxt;
      flg_r <= flg_nxt;
      chs_r <= chs_nxt;
      ctl_r <= ctl_nxt;
      res_r <= res_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  // Data stand one cycle after the strobe, zero when idle or unmapped
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_MISC_OPTION:    rdata_nxt = opt_r;
        ADDR_AUX_INT_FLAGS:  rdata_nxt = flg_r;
        ADDR_RESULT_LOW:     rdata_nxt = {res_r[3:0], 4'h0};
        ADDR_RESULT_HIGH:    rdata_nxt = res_r[11:4];
        ADDR_INPUT_CHAN_SEL: rdata_nxt = chs_r;
        ADDR_AUX_CTRL_ONE:   rdata_nxt = ctl_r;
        default:             rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Analog front-end controls
  // ---------------------------------------------------------------
  assign chan_code   = {chs_nxt[CHS_TOP_BIT], chs_nxt[CHS_FIELD_LSB +: 4]};
  assign use_bandgap = chs_nxt[CHS_REF_SEL_BIT] || (chan_code == CH_BANDGAP);

  // Decode computed from next values so outputs track the registers
  always_comb begin
    // Reserved codes and codes past the table leave the mux open
    chan_ok_nxt = (chan_code <= CH_LAST_LOW) || (chan_code == CH_BANDGAP) ||
                  (chan_code == CH_GROUND) || (chan_code == CH_QUARTER) ||
                  ((chan_code >= CH_FIRST_HIGH) && (chan_code <= CH_LAST_HIGH));
    if (ctl_nxt[CTL_FORCE_BG_BIT]) begin
      bg_en_nxt = !low_power_mode;
    end else begin
      // Automatic: only while a conversion needs the bandgap
      bg_en_nxt = (state_nxt != SADC_IDLE) && use_bandgap;
    end
  end

  // Output flops
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      chan_r    <= {INPUT_CHAN_SEL_RST[CHS_TOP_BIT], INPUT_CHAN_SEL_RST[CHS_FIELD_LSB +: 4]};
      chan_ok_r <= 1'b0;
      ref_bg_r  <= 1'b0;
      lvl_hi_r  <= 1'b0;
      lvl_lo_r  <= 1'b0;
      bg_en_r   <= 1'b0;
      sample_r  <= 1'b0;
      busy_r    <= 1'b0;
      irq_r     <= 1'b0;
    end else begin
      chan_r    <= chan_code;
      chan_ok_r <= chan_ok_nxt;
      ref_bg_r  <= chs_nxt[CHS_REF_SEL_BIT];
      lvl_hi_r  <= chs_nxt[CHS_BG_LEVEL_LSB +: 2] == BG_LEVEL_HIGH;
      lvl_lo_r  <= chs_nxt[CHS_BG_LEVEL_LSB +: 2] == BG_LEVEL_LOW;
      bg_en_r   <= bg_en_nxt;
      sample_r  <= state_nxt == SADC_SAMPLE;
      busy_r    <= state_nxt != SADC_IDLE;
      irq_r     <= flg_nxt[FLG_DONE_BIT] && conv_irq_en;
    end
  end

  // ---------------------------------------------------------------
  // Output assignments
  // ---------------------------------------------------------------
  assign reg_rdata       = rdata_r;
  assign conv_irq        = irq_r;
  assign ana_chan_sel    = chan_r;
  assign ana_chan_valid  = chan_ok_r;
  assign ana_ref_bandgap = ref_bg_r;
  assign ana_bg_level_hi = lvl_hi_r;
  assign ana_bg_level_lo = lvl_lo_r;
  assign ana_bg_enable   = bg_en_r;
  assign ana_sample      = sample_r;
  assign ana_dac_code    = sar_r;
  assign conv_clk        = conv_clk_i;
  assign busy            = busy_r;

endmodule : sadc_ctrl

// file: rtl/sadc_pkg.sv
package sadc_pkg;

  // ---------------------------------------------------------------
  // Register offsets on the 8-bit register port
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_MISC_OPTION    = 8'h94;
  localparam logic [7:0] ADDR_AUX_INT_FLAGS  = 8'h95;
  localparam logic [7:0] ADDR_RESULT_LOW     = 8'haa;
  localparam logic [7:0] ADDR_RESULT_HIGH    = 8'hab;
  localparam logic [7:0] ADDR_INPUT_CHAN_SEL = 8'hae;
  localparam logic [7:0] ADDR_AUX_CTRL_ONE   = 8'hf8;

  // ---------------------------------------------------------------
  // Reset values and writable-bit masks
  // ---------------------------------------------------------------
  localparam logic [7:0] MISC_OPTION_RST     = 8'h00;
  localparam logic [7:0] AUX_INT_FLAGS_RST   = 8'h00;
  localparam logic [7:0] INPUT_CHAN_SEL_RST  = 8'hf0;
  localparam logic [7:0] AUX_CTRL_ONE_RST    = 8'h0c;
  localparam logic [7:0] RESULT_RST          = 8'h00;
  localparam logic [7:0] MISC_OPTION_WMASK   = 8'hbf;
  localparam logic [7:0] AUX_CTRL_ONE_WMASK  = 8'hfd;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int OPT_DIV_SEL_LSB   = 2;
  localparam int FLG_DONE_BIT      = 4;
  localparam int FLG_OTHER_W       = 3;
  localparam int CHS_FIELD_LSB     = 4;
  localparam int CHS_TOP_BIT       = 3;
  localparam int CHS_REF_SEL_BIT   = 2;
  localparam int CHS_BG_LEVEL_LSB  = 0;
  localparam int CTL_FORCE_BG_BIT  = 5;
  localparam int CTL_START_BIT     = 4;
  localparam int RES_LOW_LSB       = 4;

  // ---------------------------------------------------------------
  // Converter clock divider codes and division ratios
  // ---------------------------------------------------------------
  localparam logic [1:0] DIV_BY_32 = 2'b00;
  localparam logic [1:0] DIV_BY_16 = 2'b01;
  localparam logic [1:0] DIV_BY_8  = 2'b10;
  localparam logic [1:0] DIV_BY_4  = 2'b11;
  localparam int DIV_RATIO_32 = 32;
  localparam int DIV_RATIO_16 = 16;
  localparam int DIV_RATIO_8  = 8;
  localparam int DIV_RATIO_4  = 4;

  // ---------------------------------------------------------------
  // Conversion timing in converter clocks
  // ---------------------------------------------------------------
  localparam int CONV_CLOCKS    = 50;
  localparam int CLOCKS_PER_BIT = 2;
  localparam int RESULT_BITS    = 12;
  localparam int SAMPLE_CLOCKS  = CONV_CLOCKS - CLOCKS_PER_BIT * RESULT_BITS;
  localparam logic [4:0] SAMPLE_LAST = 5'(SAMPLE_CLOCKS - 1);
  localparam logic [3:0] RESULT_MSB  = 4'(RESULT_BITS - 1);

  // ---------------------------------------------------------------
  // Channel and bandgap level codes
  // ---------------------------------------------------------------
  localparam logic [4:0] CH_LAST_LOW   = 5'h0b;
  localparam logic [4:0] CH_BANDGAP    = 5'h0c;
  localparam logic [4:0] CH_RSVD_A     = 5'h0d;
  localparam logic [4:0] CH_GROUND     = 5'h0e;
  localparam logic [4:0] CH_QUARTER    = 5'h0f;
  localparam logic [4:0] CH_FIRST_HIGH = 5'h10;
  localparam logic [4:0] CH_LAST_HIGH  = 5'h16;
  localparam logic [4:0] CH_RSVD_B     = 5'h17;
  localparam logic [1:0] BG_LEVEL_LOW  = 2'b00;
  localparam logic [1:0] BG_LEVEL_HIGH = 2'b01;

  // Sequencer phases
  typedef enum logic [1:0] {
    SADC_IDLE,
    SADC_SAMPLE,
    SADC_CONVERT
  } sadc_state_t;

endpackage : sadc_pkg

// file: rtl/sadc_clkdiv.sv
`timescale 1ns/1ps
module sadc_clkdiv
  import sadc_pkg::*;
#(
  parameter int CNT_W = 5
) (
  // System
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  // Control
  input  wire logic [1:0]       div_sel,
  input  wire logic             restart,
  // Converter clock
  output logic                  conv_tick,
  output logic                  conv_clk
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] last;
  logic             tick_r;
  logic             tick_nxt;
  logic             clk_r;
  logic             clk_nxt;

  // ---------------------------------------------------------------
  // Divider count
  // ---------------------------------------------------------------
  // Terminal count taken live, so a new setting acts on the next wrap
  always_comb begin
    unique case (div_sel)
      DIV_BY_32: last = CNT_W'(DIV_RATIO_32 - 1);
      DIV_BY_16: last = CNT_W'(DIV_RATIO_16 - 1);
      DIV_BY_8:  last = CNT_W'(DIV_RATIO_8 - 1);
      DIV_BY_4:  last = CNT_W'(DIV_RATIO_4 - 1);
    endcase
    if (restart || cnt_r >= last) begin
      cnt_nxt = '0;
    end else begin
      cnt_nxt = cnt_r + 1'b1;
    end
    // Restart gives a full first period after a start
    tick_nxt = !restart && (cnt_r >= last);
    clk_nxt  = !restart && (cnt_nxt <= (last >> 1));
  end

  // Registers
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
      clk_r  <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
      clk_r  <= clk_nxt;
    end
  end

  assign conv_tick = tick_r;
  assign conv_clk  = clk_r;

endmodule : sadc_clkdiv

// file: sim/sadc_ctrl_asserts.sv
`timescale 1ns/1ps
module sadc_ctrl_asserts
  import sadc_pkg::*;
#(
  parameter int DIV_CNT_W = 5
) (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       reset_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Interrupt and power
  input wire logic       conv_irq_en,
  input wire logic       conv_irq,
  input wire logic       low_power_mode,
  // Analog side
  input wire logic [4:0] ana_chan_sel,
  input wire logic       ana_ref_bandgap,
  input wire logic       ana_bg_level_hi,
  input wire logic       ana_bg_level_lo,
  input wire logic       ana_bg_enable,
  input wire logic       ana_sample,
  input wire logic       busy,
  input wire logic       conv_clk
);
  // -------------------------------------------------------------
  // Shadow state
  // -------------------------------------------------------------
  logic        ctl_wr, start_wr, flag_clr, chs_wr;
  logic [1:0]  div_r, div_nxt;
  logic        force_r, force_nxt;
  logic [11:0] cnt_r, cnt_nxt;
  logic [7:0]  wd_r, wd2_r;

  // Divider and force bit as software set them; busy cycles since start
  always_comb begin
    ctl_wr    = reg_wr && reg_addr == ADDR_AUX_CTRL_ONE;
    start_wr  = ctl_wr && reg_wdata[CTL_START_BIT];
    chs_wr    = reg_wr && reg_addr == ADDR_INPUT_CHAN_SEL;
    flag_clr  = reg_wr && reg_addr == ADDR_AUX_INT_FLAGS && !reg_wdata[FLG_DONE_BIT];
    div_nxt   = (reg_wr && reg_addr == ADDR_MISC_OPTION) ? reg_wdata[3:2] : div_r;
    force_nxt = ctl_wr ? reg_wdata[CTL_FORCE_BG_BIT] : force_r;
    cnt_nxt   = start_wr ? 12'h000 : (busy ? cnt_r + 12'h001 : 12'h000);
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      div_r   <= 2'b00;
      force_r <= 1'b0;
      cnt_r   <= 12'h000;
    end else begin
      div_r   <= div_nxt;
      force_r <= force_nxt;
      cnt_r   <= cnt_nxt;
    end
    wd_r  <= reg_wdata;
    wd2_r <= wd_r;
  end

  // -------------------------------------------------------------
  // Properties
  // -------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  AST_START_BUSY: assert property (start_wr |=> busy && ana_sample)
    else $error("start write did not launch a conversion");
  AST_ABORT: assert property (busy && ctl_wr && !reg_wdata[CTL_START_BIT]
    |=> (!busy && !$rose(conv_irq)) [*2])
    else $error("cleared start bit did not abandon the conversion");
  // Only whole runs are timed: an abort or restart write is excluded
  // One system clock more than 50 periods, as the divider tick is registered
  AST_CONV_LENGTH: assert property ($fell(busy) && !$past(ctl_wr)
    |-> cnt_r == 12'(CONV_CLOCKS * (DIV_RATIO_32 >> div_r) + 1))
    else $error("conversion length is not 50 converter clocks");
  AST_IRQ_AT_END: assert property ($fell(busy) && !$past(reg_wr)
    && $past(conv_irq_en) |-> conv_irq)
    else $error("no interrupt request at conversion end");
  AST_IRQ_GATE: assert property (!conv_irq_en |=> !conv_irq)
    else $error("interrupt request while disabled");
  AST_FLAG_CLEAR: assert property (start_wr || (flag_clr && !busy) |=> ##1 !conv_irq)
    else $error("done flag survived a clearing write");
  AST_LOW_NIBBLE: assert property ($past(reg_rd) && $past(reg_addr) == ADDR_RESULT_LOW
    |-> reg_rdata[3:0] == 4'h0)
    else $error("result low byte has bits in 3..0");
  AST_CHAN_SEL: assert property (chs_wr |=> ana_chan_sel == {wd_r[3], wd_r[7:4]})
    else $error("channel code not taken from the written byte");
  AST_REF_SEL: assert property (chs_wr |=> ##1 ana_ref_bandgap == wd2_r[2])
    else $error("reference select does not follow its bit");
  AST_BG_LEVEL: assert property (chs_wr |=> ##1
    {ana_bg_level_hi, ana_bg_level_lo} == {wd2_r[1:0] == 2'b01, wd2_r[1:0] == 2'b00})
    else $error("bandgap level outputs wrong for level code");
  AST_BG_FORCE: assert property (force_r && !ctl_wr
    |=> ana_bg_enable == !$past(low_power_mode))
    else $error("forced bandgap enable wrong");
  // Converter clock restarts low on a start, then begins its first period
  AST_CLK_RESTART: assert property (start_wr |=> !conv_clk ##1 conv_clk)
    else $error("converter clock did not restart with the conversion");

  // Main scenarios reached
  cover property (start_wr);
  cover property ($fell(busy) && conv_irq);
  cover property (busy && ctl_wr && !reg_wdata[CTL_START_BIT]);
endmodule : sadc_ctrl_asserts

bind sadc_ctrl sadc_ctrl_asserts #(.DIV_CNT_W(DIV_CNT_W)) u_sadc_chk (.*);

// file: sim/sadc_afe_model.sv
`timescale 1ns/1ps
module sadc_afe_model (
  // Clock
  input  wire logic        sys_clk,
  // Bench controls
  input  wire logic [11:0] ain_level,
  input  wire logic        slow,
  // From the converter control
  input  wire logic        ana_chan_valid,
  input  wire logic        ana_sample,
  input  wire logic [11:0] ana_dac_code,
  // To the converter control
  output logic             cmp_in
);
  logic [11:0] held_r;
  logic        fast_r;
  logic        lag_r;
  logic        junk_r = 1'b0;

  // Track while sampling, hold after; a dead channel answers with noise
  always_ff @(posedge sys_clk) begin
    if (ana_sample) begin
      held_r <= ain_level;
    end
    junk_r <= ~junk_r;
    fast_r <= ana_chan_valid ? (held_r >= ana_dac_code) : junk_r;
    lag_r  <= fast_r;
  end

  // Slow mode: comparator settles one cycle late
  assign cmp_in = slow ? lag_r : fast_r;
endmodule : sadc_afe_model

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import sadc_pkg::*;
;
  logic        sys_clk, reset_n, reg_wr, reg_rd, conv_irq_en, low_power_mode, slow;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [2:0]  aux_flag_set;
  logic [11:0] ana_dac_code, ain_level;
  logic [4:0]  ana_chan_sel;
  logic        conv_irq, cmp_in, ana_chan_valid, ana_ref_bandgap, ana_bg_level_hi;
  logic        ana_bg_level_lo, ana_bg_enable, ana_sample, busy;
  int          n_fail, samples_checked;

  sadc_ctrl #(.DIV_CNT_W(5)) uut (.conv_clk(), .*);
  sadc_afe_model u_afe (.*);

  // -------------------------------------------------------------
  // Bus and checking helpers
  // -------------------------------------------------------------
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task chk(input logic [11:0] seen, input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Read data stand only in the cycle after the strobe
  task rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rdchk

  task wait_idle;
    for (int i = 0; i < 1700 && busy !== 1'b0; i++) @(negedge sys_clk);
  endtask : wait_idle

  task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task t_reset;
    rdchk(ADDR_MISC_OPTION, 8'h00);
    rdchk(ADDR_AUX_INT_FLAGS, 8'h00);
    rdchk(ADDR_RESULT_HIGH, 8'h00);
    rdchk(ADDR_INPUT_CHAN_SEL, 8'hf0);
    rdchk(ADDR_AUX_CTRL_ONE, 8'h0c);
    rdchk(8'h96, 8'h00);
    chk(ana_chan_sel, 5'h0f);
    $display("done reset values");
  endtask : t_reset

  // Divider first, then channel, then start: expected result is the level
  task t_conv(input logic [1:0] dv, input logic [7:0] chs, input logic [11:0] lvl,
              input logic s);
    ain_level <= lvl;
    slow      <= s;
    wr(ADDR_MISC_OPTION, {4'h0, dv, 2'b00});
    wr(ADDR_INPUT_CHAN_SEL, chs);
    wr(ADDR_AUX_CTRL_ONE, 8'h1c);
    rdchk(ADDR_AUX_INT_FLAGS, 8'h00);
    chk(ana_bg_enable, chs[2]);
    wait_idle();
    chk(busy, 1'b0);
    chk(conv_irq, conv_irq_en);
    rdchk(ADDR_AUX_CTRL_ONE, 8'h0c);
    rdchk(ADDR_AUX_INT_FLAGS, 8'h10);
    rdchk(ADDR_RESULT_HIGH, lvl[11:4]);
    rdchk(ADDR_RESULT_LOW, {lvl[3:0], 4'h0});
    $display("done conversion");
  endtask : t_conv

  // Other flags survive the done-only clear; result bytes ignore writes
  task t_flags;
    @(posedge sys_clk);
    aux_flag_set <= 3'b101;
    @(posedge sys_clk);
    aux_flag_set <= 3'b000;
    rdchk(ADDR_AUX_INT_FLAGS, 8'h15);
    wr(ADDR_AUX_INT_FLAGS, 8'hef);
    rdchk(ADDR_AUX_INT_FLAGS, 8'h05);
    chk(conv_irq, 1'b0);
    wr(ADDR_AUX_INT_FLAGS, 8'h00);
    wr(ADDR_RESULT_LOW, 8'hff);
    wr(ADDR_RESULT_HIGH, 8'h00);
    rdchk(ADDR_AUX_INT_FLAGS, 8'h00);
    rdchk(ADDR_RESULT_HIGH, 8'ha5);
    rdchk(ADDR_RESULT_LOW, 8'hc0);
    $display("done flags");
  endtask : t_flags

  // A level that would change the result if the run went on
  task t_abort;
    ain_level <= 12'h777;
    wr(ADDR_AUX_CTRL_ONE, 8'h1c);
    rdchk(ADDR_AUX_CTRL_ONE, 8'h1c);
    wr(ADDR_AUX_CTRL_ONE, 8'h0c);
    rdchk(ADDR_AUX_CTRL_ONE, 8'h0c);
    chk(busy, 1'b0);
    repeat (220) @(negedge sys_clk);
    chk(conv_irq, 1'b0);
    rdchk(ADDR_AUX_INT_FLAGS, 8'h00);
    rdchk(ADDR_RESULT_HIGH, 8'ha5);
    $display("done abort");
  endtask : t_abort

  task t_chan;
    logic [4:0] c;
    logic       r;
    for (int i = 0; i < 32; i++) begin
      c = i[4:0];
      r = i[2] && (i[1:0] == 2'b01);
      wr(ADDR_INPUT_CHAN_SEL, {c[3:0], c[4], r, i[1:0]});
      repeat (2) @(negedge sys_clk);
      chk(ana_chan_sel, c);
      chk(ana_chan_valid, !(c == 5'h0d || c >= 5'h17));
      chk(ana_ref_bandgap, r);
      chk({ana_bg_level_hi, ana_bg_level_lo}, {i[1:0] == 2'b01, i[1:0] == 2'b00});
    end
    $display("done channels");
  endtask : t_chan

  task t_bg;
    wr(ADDR_AUX_CTRL_ONE, 8'h2c);
    low_power_mode <= 1'b1;
    repeat (2) @(negedge sys_clk);
    chk(ana_bg_enable, 1'b0);
    @(posedge sys_clk);
    low_power_mode <= 1'b0;
    repeat (2) @(negedge sys_clk);
    chk(ana_bg_enable, 1'b1);
    wr(ADDR_AUX_CTRL_ONE, 8'h0c);
    repeat (2) @(negedge sys_clk);
    chk(ana_bg_enable, 1'b0);
    $display("done bandgap force");
  endtask : t_bg

  // -------------------------------------------------------------
  // Clock, watchdog and main sequence
  // -------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Run needs about 3500 cycles; seven times that is a hang
  initial begin
    #200000;
    n_fail++;
    $display("Error t=%0t watchdog expired", $time);
    complete_run();
  end

  initial begin
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    conv_irq_en = 1'b0;
    aux_flag_set = 3'b000;
    low_power_mode = 1'b0;
    slow = 1'b0;
    ain_level = 12'h000;
    n_fail = 0;
    samples_checked = 0;
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset();
    t_conv(2'b00, 8'hb0, 12'h000, 1'b0);
    @(posedge sys_clk);
    conv_irq_en <= 1'b1;
    t_conv(2'b01, 8'h08, 12'hfff, 1'b0);
    t_conv(2'b10, 8'h35, 12'h3c1, 1'b1);
    t_conv(2'b11, 8'h68, 12'ha5c, 1'b0);
    t_flags();
    t_abort();
    t_chan();
    t_bg();
    complete_run();
  end
endmodule : tb_top
